// *** line_shape_pkg.sv ***
// Package with register map, field layout and line profile codes for the line shape block
package line_shape_pkg;

    // =========================================================
    // Register offsets (printed offsets are word indices)
    localparam logic [7:0] IDX_CHAN_POINTER = 8'h10;
    localparam logic [7:0] IDX_PROFILE_DATA = 8'h11;
    localparam logic [7:0] IDX_TX_DISABLE = 8'h12;
    localparam logic [7:0] IDX_ALARM_STATUS = 8'h13;
    localparam logic [7:0] IDX_ALARM_ENABLE = 8'h14;
    localparam logic [7:0] IDX_ALARM_FLAGS = 8'h15;
    localparam int ADDR_LSB = 2;
    localparam int IDX_W = 8;

    // =========================================================
    // Field layout and reset values
    localparam int NUM_CHAN = 8;
    localparam int PTR_W = 3;
    localparam int CODE_W = 4;
    localparam int IMP_BIT = 4;
    localparam int RSVD_MSB = 7;
    localparam int RSVD_LSB = 5;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [4:0] RESET_PROFILE = 5'h00;

    // =========================================================
    // Line profile codes
    localparam logic [3:0] CODE_E1_120 = 4'h0;
    localparam logic [3:0] CODE_T1_OPTA_US = 4'h1;
    localparam logic [3:0] CODE_T1_OPTA_0DB = 4'h2;
    localparam logic [3:0] CODE_T1_SH_FIRST = 4'h3;
    localparam logic [3:0] CODE_T1_SH_LAST = 4'h7;
    localparam logic [3:0] CODE_E1_75 = 4'h8;
    localparam logic [4:0] SAMPLES_E1 = 5'h0C;
    localparam logic [4:0] SAMPLES_OPTA = 5'h0E;
    localparam logic [4:0] SAMPLES_SH = 5'h0D;

    typedef enum {MODE_E1, MODE_T1J1, MODE_INVALID} line_mode_e;

    // Per channel setting handed to the line front end
    typedef struct packed {
        logic internal_imp;
        logic [3:0] line_profile_code;
        logic is_e1;
        logic valid;
        logic [4:0] samples_per_ui;
    } chan_cfg_s;

    // Wishbone request as seen by the slave
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [IDX_W+ADDR_LSB-1:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_s;

endpackage : line_shape_pkg

// *** profile_decode.sv ***
// Decoder from a stored line profile to the front end settings of one channel
`timescale 1ns/1ps
module profile_decode
    import line_shape_pkg::*;
(
    input wire logic [4:0] profile_i,
    output line_shape_pkg::chan_cfg_s cfg_o
);

    // =========================================================
    // Decode
    // Mode and phase sample count from the profile code
    always_comb
    begin
        cfg_o = '0;
        cfg_o.internal_imp = profile_i[IMP_BIT];
        cfg_o.line_profile_code = profile_i[CODE_W-1:0];
        if (profile_i[3:0] == CODE_E1_120 || profile_i[3:0] == CODE_E1_75)
        begin
            cfg_o.is_e1 = 1'b1;
            cfg_o.valid = 1'b1;
            cfg_o.samples_per_ui = SAMPLES_E1;
        end
        else if (profile_i[3:0] == CODE_T1_OPTA_US || profile_i[3:0] == CODE_T1_OPTA_0DB)
        begin
            cfg_o.valid = 1'b1;
            cfg_o.samples_per_ui = SAMPLES_OPTA;
        end
        else if (profile_i[3:0] >= CODE_T1_SH_FIRST && profile_i[3:0] <= CODE_T1_SH_LAST)
        begin
            cfg_o.valid = 1'b1;
            cfg_o.samples_per_ui = SAMPLES_SH;
        end
    end

endmodule : profile_decode

// *** line_shape_and_ais_regs.sv ***
// Wishbone register bank for line profile, transmit high-Z and alarm signal status
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
module line_shape_and_ais_regs
    import line_shape_pkg::*;
#(
    parameter int NCH = 8
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [NCH-1:0] ais_detect_i,
    output line_shape_pkg::chan_cfg_s [NCH-1:0] chan_cfg_o,
    output logic [NCH-1:0] tx_highz_per_channel_o,
    output logic irq_o
);
    import line_shape_pkg::*;

    // =========================================================
    // State
    logic [PTR_W-1:0] ptr_r, ptr_nxt;
    logic [4:0] profile_r [NCH];
    logic [4:0] profile_nxt [NCH];
    logic [NCH-1:0] txdis_r, txdis_nxt;
    logic [NCH-1:0] ais_s1_r, ais_s2_r, status_r, status_nxt;
    logic [NCH-1:0] enable_r, enable_nxt;
    logic [NCH-1:0] flags_r, flags_nxt;
    logic ack_r, ack_nxt;
    logic [31:0] rdat_r, rdat_nxt;
    wb_req_s req;
    logic wr_lane0;
    logic req_new;
    logic [NCH-1:0] change;
    chan_cfg_s [NCH-1:0] cfg_nxt;
    chan_cfg_s [NCH-1:0] cfg_r;

    // Decode of an all-zero profile: E1 120 ohm, external impedance
    localparam chan_cfg_s CFG_RESET = '{internal_imp: 1'b0, line_profile_code: CODE_E1_120,
        is_e1: 1'b1, valid: 1'b1, samples_per_ui: SAMPLES_E1};

    // Bundle bus inputs
    assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i,
                   sel: wb_sel_i, dat: wb_dat_i};

    // Word index decode
    function automatic logic hit(input logic [9:0] adr, input logic [7:0] idx);
        hit = (adr[IDX_W+ADDR_LSB-1:ADDR_LSB] == idx);
    endfunction : hit

    // =========================================================
    // Bus handshake
    assign req_new = req.cyc && req.stb && !ack_r;
    assign wr_lane0 = req_new && req.we && req.sel[0];

    // Alarm status change detection
    assign change = status_nxt ^ status_r;

    // Next state of all registers except the alarm synchronizer and the decoded settings
    always_comb
    begin
        ptr_nxt = ptr_r;
        txdis_nxt = txdis_r;
        enable_nxt = enable_r;
        flags_nxt = flags_r;
        for (int i = 0; i < NCH; i++)
        begin
            profile_nxt[i] = profile_r[i];
        end
        status_nxt = ais_s2_r;
        ack_nxt = req_new;
        rdat_nxt = rdat_r;
        if (wr_lane0 && hit(req.adr, IDX_CHAN_POINTER))
        begin
            ptr_nxt = req.dat[PTR_W-1:0];
        end
        if (wr_lane0 && hit(req.adr, IDX_PROFILE_DATA))
        begin
            profile_nxt[ptr_r] = req.dat[4:0];
        end
        if (wr_lane0 && hit(req.adr, IDX_TX_DISABLE))
        begin
            txdis_nxt = req.dat[NCH-1:0];
        end
        if (wr_lane0 && hit(req.adr, IDX_ALARM_ENABLE))
        begin
            enable_nxt = req.dat[NCH-1:0];
        end
        if (wr_lane0 && hit(req.adr, IDX_ALARM_FLAGS))
        begin
            flags_nxt = flags_r & ~req.dat[NCH-1:0];
        end
        // Set wins over clear
        flags_nxt = flags_nxt | (change & enable_r);
        if (req_new && !req.we)
        begin
            rdat_nxt = 32'h0000_0000;
            if (hit(req.adr, IDX_CHAN_POINTER))
                rdat_nxt[PTR_W-1:0] = ptr_r;
            else if (hit(req.adr, IDX_PROFILE_DATA))
                rdat_nxt[4:0] = profile_r[ptr_r];
            else if (hit(req.adr, IDX_TX_DISABLE))
                rdat_nxt[NCH-1:0] = txdis_r;
            else if (hit(req.adr, IDX_ALARM_STATUS))
                rdat_nxt[NCH-1:0] = status_r;
            else if (hit(req.adr, IDX_ALARM_ENABLE))
                rdat_nxt[NCH-1:0] = enable_r;
            else if (hit(req.adr, IDX_ALARM_FLAGS))
                rdat_nxt[NCH-1:0] = flags_r;
        end
    end

    // Register all state except the decoded settings
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ptr_r <= '0;
            txdis_r <= '0;
            enable_r <= '0;
            flags_r <= '0;
            status_r <= '0;
            ais_s1_r <= '0;
            ais_s2_r <= '0;
            ack_r <= 1'b0;
            rdat_r <= 32'h0000_0000;
            for (int i = 0; i < NCH; i++)
            begin
                profile_r[i] <= RESET_PROFILE;
            end
        end
        else
        begin
            ptr_r <= ptr_nxt;
            txdis_r <= txdis_nxt;
            enable_r <= enable_nxt;
            flags_r <= flags_nxt;
            status_r <= status_nxt;
            ais_s1_r <= ais_detect_i;
            ais_s2_r <= ais_s1_r;
            ack_r <= ack_nxt;
            rdat_r <= rdat_nxt;
            for (int i = 0; i < NCH; i++)
            begin
                profile_r[i] <= profile_nxt[i];
            end
        end
    end

    // =========================================================
    // Outputs
    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdat_r;
    assign tx_highz_per_channel_o = txdis_r;
    assign irq_o = |flags_r;
    assign chan_cfg_o = cfg_r;

    // Per channel decode of stored profile
    generate
        for (genvar g = 0; g < NCH; g++)
        begin : g_dec
            profile_decode u_dec (
                .profile_i(profile_r[g]),
                .cfg_o(cfg_nxt[g])
            );
        end
    endgenerate

    // Register the decoded settings so the line side sees flop outputs
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cfg_r <= {NCH{CFG_RESET}};
        end
        else
        begin
            cfg_r <= cfg_nxt;
        end
    end

    // =========================================================
    // Assertions
    sequence s_ptr_write;
        wr_lane0 && hit(req.adr, IDX_CHAN_POINTER);
    endsequence

    sequence s_prof_write;
        wr_lane0 && hit(req.adr, IDX_PROFILE_DATA);
    endsequence

    sequence s_flag_clear;
        wr_lane0 && hit(req.adr, IDX_ALARM_FLAGS);
    endsequence

    sequence s_status_write;
        req_new && req.we && hit(req.adr, IDX_ALARM_STATUS);
    endsequence

    sequence s_read_req;
        req_new && !req.we;
    endsequence

    chk_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    chk_ptr_select: assert property (@(posedge clk_i) disable iff (rst_i)
        s_ptr_write |=> ptr_r == $past(wb_dat_i[2:0]))
        else $error("pointer not loaded");

    chk_profile_store: assert property (@(posedge clk_i) disable iff (rst_i)
        s_prof_write |=> profile_r[$past(ptr_r)] == $past(wb_dat_i[4:0]))
        else $error("profile not stored for pointed channel");

    chk_imp_source: assert property (@(posedge clk_i) disable iff (rst_i)
        s_prof_write |=> ##1 chan_cfg_o[$past(ptr_r, 2)].internal_imp == $past(wb_dat_i[4], 2))
        else $error("impedance select wrong");

    chk_cfg_follow: assert property (@(posedge clk_i) disable iff (rst_i)
        s_prof_write
        |=> ##1 chan_cfg_o[$past(ptr_r, 2)].line_profile_code == $past(wb_dat_i[3:0], 2))
        else $error("profile code not applied to pointed channel");

    chk_e1_samples: assert property (@(posedge clk_i) disable iff (rst_i)
        chan_cfg_o[0].is_e1 |-> chan_cfg_o[0].samples_per_ui == 5'h0C)
        else $error("E1 sample count wrong");

    chk_short_haul: assert property (@(posedge clk_i) disable iff (rst_i)
        (profile_r[0][3:0] >= 4'h3 && profile_r[0][3:0] <= 4'h7)
        |=> chan_cfg_o[0].samples_per_ui == 5'h0D && !chan_cfg_o[0].is_e1)
        else $error("short haul decode wrong");

    chk_opta: assert property (@(posedge clk_i) disable iff (rst_i)
        (profile_r[1][3:0] == 4'h1 || profile_r[1][3:0] == 4'h2)
        |=> chan_cfg_o[1].samples_per_ui == 5'h0E)
        else $error("option A decode wrong");

    chk_txdis_drive: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_lane0 && hit(req.adr, IDX_TX_DISABLE))
        |=> tx_highz_per_channel_o == $past(wb_dat_i[7:0]))
        else $error("tx disable not applied");

    chk_status_ro: assert property (@(posedge clk_i) disable iff (rst_i)
        status_r == $past(ais_s2_r))
        else $error("status not following detector");

    chk_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
        (|(change & enable_r)) |=> (flags_r & $past(change & enable_r)) == $past(change & enable_r))
        else $error("change flag not set");

    chk_irq_flags: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(irq_o) |-> |($past(change & enable_r)))
        else $error("interrupt rose without an enabled change");

    chk_flag_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        (flags_r & ~$past(flags_r) & ~$past(enable_r)) == '0)
        else $error("flag set while its enable was clear");

    chk_flag_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        s_flag_clear ##0 ((change & enable_r) == '0)
        |=> (flags_r & $past(req.dat[NCH-1:0])) == '0)
        else $error("flag not cleared by a written one");

    chk_status_nowrite: assert property (@(posedge clk_i) disable iff (rst_i)
        s_status_write |=> status_r == $past(ais_s2_r))
        else $error("status changed by a host write");

    chk_lane0_ignore: assert property (@(posedge clk_i) disable iff (rst_i)
        (req_new && req.we && !req.sel[0])
        |=> $stable(txdis_r) && $stable(ptr_r) && $stable(enable_r))
        else $error("write without byte lane 0 took effect");

    chk_ptr_read: assert property (@(posedge clk_i) disable iff (rst_i)
        s_read_req ##0 hit(req.adr, IDX_CHAN_POINTER)
        |=> wb_ack_o && wb_dat_o[PTR_W-1:0] == $past(ptr_r))
        else $error("pointer read back wrong");

    chk_profile_read: assert property (@(posedge clk_i) disable iff (rst_i)
        s_read_req ##0 hit(req.adr, IDX_PROFILE_DATA)
        |=> wb_ack_o && wb_dat_o[4:0] == $past(profile_r[ptr_r]))
        else $error("profile read back wrong");

    chk_status_read: assert property (@(posedge clk_i) disable iff (rst_i)
        s_read_req ##0 hit(req.adr, IDX_ALARM_STATUS)
        |=> wb_ack_o && wb_dat_o[NCH-1:0] == $past(status_r))
        else $error("alarm status read back wrong");

endmodule : line_shape_and_ais_regs

// *** wb_host_model.sv ***
// Wishbone host model issuing single classic cycles to the register bank
`timescale 1ns/1ps
module wb_host_model
(
    input wire logic clk_i,
    input wire logic ack_i,
    input wire logic [31:0] dat_i,
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [9:0] adr_o,
    output logic [3:0] sel_o,
    output logic [31:0] dat_o
);
    // =========================================================
    // Idle bus at time zero
    initial
    begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o = 1'b0;
        adr_o = 10'h000;
        sel_o = 4'h0;
        dat_o = 32'h0;
    end

    // One cycle held until ack is sampled or 20 clocks pass, then released with scrambled lines
    task automatic xfer(input logic w, input logic [9:0] a, input logic [3:0] s,
                        input logic [7:0] d, output logic [31:0] rd, output bit to);
        int n;
        to = 1'b1;
        rd = 32'h0;
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= w;
        adr_o <= a;
        sel_o <= s;
        dat_o <= {24'h0, d};
        for (n = 0; n < 20 && to; n++)
        begin
            @(posedge clk_i);
            if (ack_i === 1'b1)
            begin
                rd = dat_i;
                to = 1'b0;
            end
        end
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        adr_o <= ~a;
        dat_o <= ~{24'h0, d};
    endtask : xfer
endmodule : wb_host_model

// *** line_shape_and_ais_regs_tb.sv ***
// Self-checking testbench for the line shape and alarm register bank
`timescale 1ns/1ps
module line_shape_and_ais_regs_tb;
    import line_shape_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] ais_r = 8'h00;
    logic cyc, stb, we, ack, irq;
    logic [9:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, rd;
    chan_cfg_s [7:0] cfg;
    logic [7:0] highz;
    int bad_count = 0;
    int n_compared = 0;
    int seed = 32'h553ef508;
    int prof_q[8];
    int k, r;
    bit to;

    // =========================================================
    // Design and host model
    line_shape_and_ais_regs #(.NCH(8)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .ais_detect_i(ais_r),
        .chan_cfg_o(cfg), .tx_highz_per_channel_o(highz), .irq_o(irq));
    wb_host_model i_host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc),
        .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));

    // Clock of 100 ns period
    initial
    begin
        forever #50 clk_i = ~clk_i;
    end

    // Verdict and end of run
    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic bus(input logic w, input logic [9:0] a, input logic [3:0] s,
                       input logic [7:0] d);
        i_host.xfer(w, a, s, d, rd, to);
        if (to)
        begin
            bad_count++;
            $display("wrong value at %0t: no acknowledge", $time);
            conclude();
        end
    endtask : bus

    // Reference channel setting from a stored profile
    function automatic logic [31:0] exp_cfg(input int p);
        int c;
        logic [4:0] smp;
        c = p % 16;
        smp = (c == 0 || c == 8) ? 5'h0C : (c == 1 || c == 2) ? 5'h0E :
              (c >= 3 && c <= 7) ? 5'h0D : 5'h00;
        return {20'h0, p[4], c[3:0], c == 0 || c == 8, c <= 8, smp};
    endfunction : exp_cfg

    // =========================================================
    // Main sequence
    initial
    begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        for (k = 0; k < 6; k++)
        begin
            bus(1'b0, 10'h040 + 10'(4 * k), 4'hF, 8'h00);
            check(rd, 32'h0);
        end
        check({24'h0, highz}, 32'h0);
        // Codes 0 to 8, then random codes, on a rotating channel, random impedance source
        for (k = 0; k < 16; k++)
        begin
            r = (k < 9) ? k : ($unsigned($random(seed)) % 16);
            r = r + 16 * ($random(seed) & 1);
            prof_q[k % 8] = r;
            bus(1'b1, 10'h040, 4'hF, 8'(k % 8));
            bus(1'b1, 10'h044, 4'hF, 8'(r));
            @(negedge clk_i);
            check({20'h0, cfg[k % 8]}, exp_cfg(r));
        end
        for (k = 0; k < 8; k++)
        begin
            bus(1'b1, 10'h040, 4'hF, 8'(7 - k));
            bus(1'b0, 10'h044, 4'hF, 8'h00);
            check(rd, 32'(prof_q[7 - k]));
            check({20'h0, cfg[7 - k]}, exp_cfg(prof_q[7 - k]));
        end
        // Driver high-Z, with a write lacking byte lane 0
        r = $random(seed);
        bus(1'b1, 10'h048, 4'hF, r[7:0]);
        bus(1'b1, 10'h048, 4'hE, ~r[7:0]);
        bus(1'b0, 10'h048, 4'hF, 8'h00);
        check(rd, {24'h0, r[7:0]});
        check({24'h0, highz}, {24'h0, r[7:0]});
        // Alarm detect, flags, interrupt, mask
        bus(1'b1, 10'h050, 4'hF, 8'hFF);
        r = $random(seed) | 1;
        ais_r <= r[7:0];
        repeat (6) @(posedge clk_i);
        bus(1'b1, 10'h04C, 4'hF, ~r[7:0]);
        bus(1'b0, 10'h04C, 4'hF, 8'h00);
        check(rd, {24'h0, r[7:0]});
        bus(1'b0, 10'h054, 4'hF, 8'h00);
        check(rd, {24'h0, r[7:0]});
        check({31'h0, irq}, 32'h1);
        bus(1'b1, 10'h054, 4'hF, 8'hFF);
        bus(1'b0, 10'h054, 4'hF, 8'h00);
        repeat (2) @(negedge clk_i);
        check(rd, 32'h0);
        check({31'h0, irq}, 32'h0);
        bus(1'b1, 10'h050, 4'hF, 8'h00);
        ais_r <= ~r[7:0];
        repeat (6) @(posedge clk_i);
        bus(1'b0, 10'h054, 4'hF, 8'h00);
        repeat (2) @(negedge clk_i);
        check(rd, 32'h0);
        check({31'h0, irq}, 32'h0);
        bus(1'b0, 10'h04C, 4'hF, 8'h00);
        check(rd, {24'h0, ~r[7:0]});
        bus(1'b0, 10'h07C, 4'hF, 8'h00);
        check(rd, 32'h0);
        conclude();
    end
endmodule : line_shape_and_ais_regs_tb
